// file: gauge_regs.v
`timescale 1ns/100ps
`include "gauge_map.vh"
module gauge_regs (
  // clock and reset
  input wire MCLK_I,
  input wire RST_I,
  // i2c pins, open drain
  input wire SCL_I,
  input wire SDA_I,
  output reg SDA_O,
  output reg SDA_OE_O,
  // alarm pin, open drain
  input wire ALARM_PIN_I,
  output reg ALARM_PIN_O,
  output reg ALARM_PIN_OE_O,
  // factory address select
  input wire [2:0] ADDR_SEL_I,
  // converter results and events from the analog front end
  input wire [15:0] CURRENT_I,
  input wire [15:0] VOLTAGE_I,
  input wire CUR_DONE_I,
  input wire VOLT_DONE_I,
  // measurement sequencing to the front end
  output reg CONV_VOLT_O,
  output reg CONV_START_O,
  output reg CONV_ABORT_O,
  output reg POWER_SAVE_O,
  output reg [15:0] CHARGE_O
);
  // synchronisers for pins
  reg [1:0] scl_s, sda_s, alm_s;
  reg scl_q, sda_q;
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      alm_s <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], SCL_I};
      sda_s <= {sda_s[0], SDA_I};
      alm_s <= {alm_s[0], ALARM_PIN_I};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
    end
  end
  wire scl_rise = ~scl_q & scl_s[1];
  wire scl_fall = scl_q & ~scl_s[1];
  wire start_c = scl_s[1] & sda_q & ~sda_s[1];
  wire stop_c = scl_s[1] & ~sda_q & sda_s[1];

  // address select is a strap pin; resync it so a late strap cannot glitch a match
  reg [2:0] asel_s1_q, asel_q;
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      asel_s1_q <= 3'h0;
      asel_q <= 3'h0;
    end else begin
      asel_s1_q <= ADDR_SEL_I;
      asel_q <= asel_s1_q;
    end
  end

  // i2c slave states
  localparam S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h2, S_INDEX = 3'h3;
  localparam S_WDATA = 3'h4, S_RDATA = 3'h5, S_RACK = 3'h6, S_WACK = 3'h7;
  reg [2:0] st_q;
  reg [7:0] sh_q;
  reg [3:0] bit_q;
  reg rw_q, have_ix_q, drive_ack_q;
  reg [7:0] ix_q;
  reg wr_stb, rd_adv;

  // registers
  reg [7:0] mode_q, base_l_q, base_h_q, als_l_q, als_h_q, alv_q, thr_q, relax_q;
  reg drv_q, por_q, lchg_q, lvol_q, geoc_q, veoc_q;
  reg [7:0] ram_q [0:15];
  reg [27:0] acc_q;
  reg [15:0] cnt_q, cur_q, vol_q;
  // snapshot taken at address phase so multi-byte reads agree
  reg [15:0] snap_chg_q, snap_cnt_q, snap_cur_q, snap_vol_q;

  // read decode, used at load and at snapshot-free registers
  function [7:0] rd_mux;
    input [7:0] ix;
    begin
      case (ix)
        `IX_MODE: rd_mux = mode_q & 8'h1E;
        `IX_CTRL: rd_mux = {1'b0, lvol_q, lchg_q, por_q, veoc_q, geoc_q, 1'b0, alm_s[1]};
        `IX_CHG_L: rd_mux = snap_chg_q[7:0];
        `IX_CHG_H: rd_mux = snap_chg_q[15:8];
        `IX_CNT_L: rd_mux = snap_cnt_q[7:0];
        `IX_CNT_H: rd_mux = snap_cnt_q[15:8];
        `IX_CUR_L: rd_mux = snap_cur_q[7:0];
        `IX_CUR_H: rd_mux = snap_cur_q[15:8];
        `IX_VOL_L: rd_mux = snap_vol_q[7:0];
        `IX_VOL_H: rd_mux = snap_vol_q[15:8];
        `IX_BASE_L: rd_mux = base_l_q;
        `IX_BASE_H: rd_mux = base_h_q;
        `IX_ALS_L: rd_mux = als_l_q;
        `IX_ALS_H: rd_mux = als_h_q;
        `IX_ALV: rd_mux = alv_q;
        `IX_THR: rd_mux = thr_q;
        `IX_RELAX: rd_mux = relax_q;
        `IX_ID: rd_mux = `PART_ID;
        default: rd_mux = (ix >= `IX_RAM_LO && ix <= `IX_RAM_HI) ? ram_q[ix[3:0]] : 8'h00;
      endcase
    end
  endfunction

  // byte that the next read load puts on the wire
  wire [7:0] rd_now = rd_mux(ix_q);
  wire [15:0] charge_w = acc_q[27:12] + {base_h_q, base_l_q};
  wire addr_hit = (sh_q[7:4] == `ADDR_HI) && (sh_q[3:1] == asel_q);

  // serial engine: msb first, ack on ninth clock
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= S_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      rw_q <= 1'b0;
      have_ix_q <= 1'b0;
      ix_q <= 8'h00;
      drive_ack_q <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE_O <= 1'b0;
      wr_stb <= 1'b0;
      rd_adv <= 1'b0;
      snap_chg_q <= 16'h0000;
      snap_cnt_q <= 16'h0000;
      snap_cur_q <= 16'h0000;
      snap_vol_q <= 16'h0000;
    end else begin
      wr_stb <= 1'b0;
      rd_adv <= 1'b0;
      if (start_c) begin
        st_q <= S_ADDR;
        bit_q <= 4'h0;
        SDA_OE_O <= 1'b0;
      end else if (stop_c) begin
        st_q <= S_IDLE;
        have_ix_q <= 1'b0;
        SDA_OE_O <= 1'b0;
      end else if (scl_rise) begin
        case (st_q)
          S_ADDR, S_INDEX, S_WDATA: begin
            sh_q <= {sh_q[6:0], sda_q};
            bit_q <= bit_q + 4'h1;
          end
          S_RACK: if (sda_q) st_q <= S_IDLE; // master nack ends read, ack waits for fall
          default: st_q <= st_q;
        endcase
      end else if (scl_fall) begin
        case (st_q)
          S_ADDR: if (bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (addr_hit) begin
              rw_q <= sh_q[0];
              st_q <= S_AACK;
              SDA_OE_O <= 1'b1;
              snap_chg_q <= charge_w;
              snap_cnt_q <= cnt_q;
              snap_cur_q <= cur_q;
              snap_vol_q <= vol_q;
            end else st_q <= S_IDLE;
          end
          S_AACK: begin
            if (rw_q) begin
              st_q <= S_RDATA;
              sh_q <= rd_now;
              SDA_OE_O <= ~rd_now[7];
              bit_q <= 4'h1;
            end else begin
              st_q <= have_ix_q ? S_WDATA : S_INDEX;
              SDA_OE_O <= 1'b0;
            end
          end
          S_INDEX: if (bit_q == 4'h8) begin
            ix_q <= sh_q;
            have_ix_q <= 1'b1;
            st_q <= S_AACK;
            bit_q <= 4'h0;
            SDA_OE_O <= 1'b1;
          end
          S_WDATA: if (bit_q == 4'h8) begin
            wr_stb <= 1'b1;
            st_q <= S_WACK;
            bit_q <= 4'h0;
            SDA_OE_O <= 1'b1;
          end
          S_WACK: begin
            ix_q <= ix_q + 8'h01; // auto-increment
            st_q <= S_WDATA;
            SDA_OE_O <= 1'b0;
          end
          S_RDATA: if (bit_q == 4'h8) begin
            SDA_OE_O <= 1'b0;
            st_q <= S_RACK;
            rd_adv <= 1'b1;
            ix_q <= ix_q + 8'h01;
          end else begin
            SDA_OE_O <= ~sh_q[7 - bit_q[2:0]];
            bit_q <= bit_q + 4'h1;
          end
          S_RACK: begin
            st_q <= S_RDATA;
            sh_q <= rd_now;
            SDA_OE_O <= ~rd_now[7];
            bit_q <= 4'h1;
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // 32768 Hz tick from the system clock
  reg [11:0] div_q;
  reg tick;
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_q <= 12'h000;
      tick <= 1'b0;
    end else begin
      tick <= (div_q == 12'h000);
      div_q <= (div_q == 12'h000) ? `TICK_RELOAD : div_q - 12'h001;
    end
  end

  // measurement sequencer: one voltage then seven current periods per 3.75 s
  localparam Q_STOP = 2'h0, Q_VOLT = 2'h1, Q_CUR = 2'h2;
  reg [1:0] seq_q;
  reg [13:0] tcnt_q;
  reg [2:0] slot_q;
  reg vpair_q;
  wire run = mode_q[`B_RUN];
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      seq_q <= Q_STOP;
      tcnt_q <= 14'h0000;
      slot_q <= 3'h0;
      CONV_VOLT_O <= 1'b0;
      CONV_START_O <= 1'b0;
      CONV_ABORT_O <= 1'b0;
    end else begin
      CONV_START_O <= 1'b0;
      CONV_ABORT_O <= 1'b0;
      if (!run) begin
        if (seq_q != Q_STOP)
          CONV_ABORT_O <= 1'b1;
        seq_q <= Q_STOP;
      end else if (seq_q == Q_STOP) begin
        seq_q <= Q_VOLT;
        CONV_VOLT_O <= 1'b1;
        CONV_START_O <= 1'b1;
        tcnt_q <= `VCONV_TICKS;
        slot_q <= 3'h0;
      end else if (tick) begin
        if (tcnt_q != 14'h0000) tcnt_q <= tcnt_q - 14'h0001;
        else begin
          slot_q <= slot_q + 3'h1;
          CONV_START_O <= 1'b1;
          if (slot_q == `VOLT_PERIOD) begin
            seq_q <= Q_VOLT;
            CONV_VOLT_O <= 1'b1;
            tcnt_q <= `VCONV_TICKS;
          end else begin
            seq_q <= Q_CUR;
            CONV_VOLT_O <= 1'b0;
            tcnt_q <= `ICONV_TICKS;
          end
        end
      end
    end
  end

  // alarm conditions, evaluated on new results
  wire low_chg = $signed(charge_w) < $signed({als_h_q, als_l_q});
  wire low_vol = vol_q[15:8] < alv_q;
  reg armc_q, armv_q, pin_low;
  wire wr_ctrl = wr_stb && ix_q == `IX_CTRL;
  wire wr_mode = wr_stb && ix_q == `IX_MODE;
  wire soft_rst = wr_ctrl && sh_q[`B_POR];

  // register writes, accumulation, alarm and relaxation logic
  integer k;
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_q <= 8'h00;
      drv_q <= 1'b1;
      por_q <= 1'b1;
      {lchg_q, lvol_q, geoc_q, veoc_q} <= 4'h0;
      {base_l_q, base_h_q, als_l_q, als_h_q, alv_q, thr_q, relax_q} <= 56'h0;
      {armc_q, armv_q, vpair_q} <= 3'h7;
      acc_q <= 28'h0;
      {cnt_q, cur_q, vol_q} <= 48'h0;
      CHARGE_O <= 16'h0000;
      POWER_SAVE_O <= 1'b0;
      ALARM_PIN_O <= 1'b0;
      ALARM_PIN_OE_O <= 1'b0;
      for (k = 0; k < 16; k = k + 1) ram_q[k] <= 8'h00;
    end else if (soft_rst) begin
      mode_q <= 8'h00;
      drv_q <= 1'b1;
      por_q <= 1'b1;
      {lchg_q, lvol_q, geoc_q, veoc_q} <= 4'h0;
      {base_l_q, base_h_q, als_l_q, als_h_q, alv_q, thr_q, relax_q} <= 56'h0;
      {armc_q, armv_q, vpair_q} <= 3'h7;
      acc_q <= 28'h0;
      cnt_q <= 16'h0000;
    end else begin
      CHARGE_O <= charge_w;
      POWER_SAVE_O <= mode_q[`B_SAVE];
      if (wr_mode) mode_q <= sh_q & 8'h1E;
      if (wr_stb) begin
        case (ix_q)
          `IX_BASE_L: base_l_q <= sh_q;
          `IX_BASE_H: base_h_q <= sh_q;
          `IX_ALS_L: als_l_q <= sh_q;
          `IX_ALS_H: als_h_q <= sh_q;
          `IX_ALV: alv_q <= sh_q;
          `IX_THR: thr_q <= sh_q;
          default: if (ix_q >= `IX_RAM_LO && ix_q <= `IX_RAM_HI) ram_q[ix_q[3:0]] <= sh_q;
        endcase
      end
      // event flags clear on read of ctrl, a new event wins
      if (rd_adv && ix_q == `IX_CTRL + 8'h01) {geoc_q, veoc_q} <= 2'b00;
      if (CUR_DONE_I && run) geoc_q <= 1'b1;
      if (VOLT_DONE_I && run) veoc_q <= 1'b1;
      if (wr_ctrl) begin
        drv_q <= sh_q[`B_DRV];
        por_q <= 1'b0;
      end
      // current result accumulates each 500 ms conversion
      if (wr_ctrl && sh_q[`B_CLR]) begin
        acc_q <= 28'h0;
        cnt_q <= 16'h0000;
      end else if (CUR_DONE_I && run) begin
        cur_q <= CURRENT_I;
        acc_q <= acc_q + {{12{CURRENT_I[15]}}, CURRENT_I};
        cnt_q <= cnt_q + 16'h0001;
      end
      if (VOLT_DONE_I && run) begin
        vol_q <= VOLTAGE_I;
        vpair_q <= ~vpair_q;
        // relax counter: light load is -thr*128 < current < 0
        if (!cur_q[15] || cur_q == 16'h0000 ||
            $signed(cur_q) <= -$signed({1'b0, thr_q, 7'h00}))
          relax_q <= 8'h00;
        else if (vpair_q && relax_q != `RELAX_MAX)
          relax_q <= relax_q + 8'h01;
      end
      // per-source trigger, rearm only after condition drops
      if (wr_ctrl && !sh_q[`B_LCHG]) lchg_q <= 1'b0;
      if (wr_ctrl && !sh_q[`B_LVOL]) lvol_q <= 1'b0;
      if (!low_chg) armc_q <= 1'b1;
      else if (mode_q[`B_AEN] && armc_q && CUR_DONE_I) begin
        lchg_q <= 1'b1;
        armc_q <= 1'b0;
      end
      if (!low_vol) armv_q <= 1'b1;
      else if (mode_q[`B_AEN] && armv_q && VOLT_DONE_I) begin
        lvol_q <= 1'b1;
        armv_q <= 1'b0;
      end
      ALARM_PIN_O <= 1'b0;
      ALARM_PIN_OE_O <= pin_low;
    end
  end

  // pin low when forced or while alarm enabled and any flag latched
  always @* begin
    pin_low = ~drv_q | (mode_q[`B_AEN] & (lchg_q | lvol_q));
  end
endmodule

// file: gauge_map.vh
// How it works
// - alarm drive 0 forces pin low
// - drive bit reads sampled pin level
// - enabled alarm pulls pin on low conditions
// - trigger drives pin, sets matching flag
// - pin stays low until both flags cleared
// - cleared flag needs condition to fall first
// - each alarm source tracked separately
// - reset clears enable, levels, base, relax count
// - relax counter counts in light-load window
// - 8-bit relax count, every two voltages, saturates
// - charging or heavy discharge clears relax count
// - current threshold is 8-bit read/write
// - first conversion after run is voltage
// - charge updated every 500 ms from current
// - run cleared stops and aborts conversion
// - i2c slave, msb first
// - address 1110 plus three select bits
// - start, address, index, data, acks
// - id at 24, scratch 32 to 47
// - multi-byte reads are coherent snapshots
// - reset restores defaults, sets power-on bit
// - low charge bit 5, low voltage bit 6
// - mode bits 2 save, 3 enable, 4 run
// - drive bit is ctrl bit 0, default 1
// - gauge clear resets accumulator and counter
`ifndef GAUGE_MAP_VH
`define GAUGE_MAP_VH
`define IX_MODE 8'h00
`define IX_CTRL 8'h01
`define IX_CHG_L 8'h02
`define IX_CHG_H 8'h03
`define IX_CNT_L 8'h04
`define IX_CNT_H 8'h05
`define IX_CUR_L 8'h06
`define IX_CUR_H 8'h07
`define IX_VOL_L 8'h08
`define IX_VOL_H 8'h09
`define IX_BASE_L 8'h0A
`define IX_BASE_H 8'h0B
`define IX_ALS_L 8'h0C
`define IX_ALS_H 8'h0D
`define IX_ALV 8'h0E
`define IX_THR 8'h0F
`define IX_RELAX 8'h10
`define IX_ID 8'h18
`define IX_RAM_LO 8'h20
`define IX_RAM_HI 8'h2F
`define B_SAVE 2
`define B_AEN 3
`define B_RUN 4
`define B_DRV 0
`define B_CLR 1
`define B_GEOC 2
`define B_VEOC 3
`define B_POR 4
`define B_LCHG 5
`define B_LVOL 6
`define ADDR_HI 4'hE
// part code is arbitrary, chosen only to be recognisable on the bus
`define PART_ID 8'h5A
`define RELAX_MAX 8'hFF
`define TICK_HZ 32768
`define MCLK_HZ 100000000
`define TICK_DIV (`MCLK_HZ / `TICK_HZ)
`define TICK_RELOAD 12'hBEA
`define VCONV_TICKS 14'h2000
`define ICONV_TICKS 14'h3FFF
`define VOLT_PERIOD 3'h7
`endif

// file: gauge_regs_chk.sv
`timescale 1ns/100ps
module gauge_regs_chk (
  // watched ports
  input wire MCLK_I,
  input wire RST_I,
  input wire SCL_I,
  input wire SDA_O,
  input wire SDA_OE_O,
  input wire ALARM_PIN_O,
  input wire ALARM_PIN_OE_O,
  input wire CUR_DONE_I,
  input wire VOLT_DONE_I,
  input wire CONV_VOLT_O,
  input wire CONV_START_O,
  input wire CONV_ABORT_O,
  input wire POWER_SAVE_O
);
  logic [7:0] scl_age_q;
  logic [7:0] done_age_q;
  logic fresh_q;
  default clocking dcb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // ages since host clock low and since a converter event; saturate so they never wrap
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_age_q <= 8'hFF;
      done_age_q <= 8'hFF;
      fresh_q <= 1'b1;
    end else begin
      scl_age_q <= !SCL_I ? 8'h00 : scl_age_q + {7'h00, scl_age_q != 8'hFF};
      done_age_q <= (CUR_DONE_I || VOLT_DONE_I) ? 8'h00 : done_age_q + {7'h00, done_age_q != 8'hFF};
      fresh_q <= CONV_ABORT_O ? 1'b1 : (CONV_START_O ? 1'b0 : fresh_q);
    end
  end
  AST_SDA_OPEN_DRAIN: assert property (SDA_OE_O |-> SDA_O == 1'b0)
    else $error("sda driven high");
  AST_SDA_ON_LOW: assert property ($changed(SDA_OE_O) |-> scl_age_q < 8'h08)
    else $error("sda moved outside clock low");
  AST_ALM_OPEN_DRAIN: assert property (ALARM_PIN_OE_O |-> ALARM_PIN_O == 1'b0)
    else $error("alarm pin driven high");
  AST_ALM_HELD: assert property ($fell(ALARM_PIN_OE_O) |-> scl_age_q < 8'h08)
    else $error("alarm released without host write");
  AST_ALM_CAUSE: assert property ($rose(ALARM_PIN_OE_O) |-> done_age_q < 8'h10 || scl_age_q < 8'h08)
    else $error("alarm raised without cause");
  AST_START_PULSE: assert property ($rose(CONV_START_O) |=> !CONV_START_O)
    else $error("start longer than one cycle");
  AST_VOLT_FIRST: assert property (CONV_START_O && fresh_q |-> CONV_VOLT_O)
    else $error("first conversion not voltage");
  AST_ABORT_ALONE: assert property (CONV_ABORT_O |-> !CONV_START_O ##1 !CONV_ABORT_O)
    else $error("abort overlaps start or lasts");
  AST_SAVE_BY_HOST: assert property ($changed(POWER_SAVE_O) |-> scl_age_q < 8'h08)
    else $error("power save changed without write");
endmodule
bind gauge_regs gauge_regs_chk u_chk (.MCLK_I(MCLK_I), .RST_I(RST_I), .SCL_I(SCL_I),
  .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .ALARM_PIN_O(ALARM_PIN_O),
  .ALARM_PIN_OE_O(ALARM_PIN_OE_O), .CUR_DONE_I(CUR_DONE_I), .VOLT_DONE_I(VOLT_DONE_I),
  .CONV_VOLT_O(CONV_VOLT_O), .CONV_START_O(CONV_START_O), .CONV_ABORT_O(CONV_ABORT_O),
  .POWER_SAVE_O(POWER_SAVE_O));

// file: i2c_host.sv
`timescale 1ns/100ps
module i2c_host (
  // bus side, data line open drain, clock driven push-pull
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  localparam realtime TQ = 31.25;
  // idle bus: clock high and still, data released
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // data moves a quarter after the fall so it never races the clock edge
  task automatic bit_io(input logic b, output logic r);
    #TQ;
    sda_oe_o = !b;
    #TQ;
    scl_o = 1'b1;
    #TQ;
    r = sda_i;
    #TQ;
    scl_o = 1'b0;
  endtask
  // extra quarter first: the slave may still hold its ack
  task automatic start_c;
    #TQ;
    sda_oe_o = 1'b0;
    #TQ;
    scl_o = 1'b1;
    #TQ;
    sda_oe_o = 1'b1;
    #TQ;
    scl_o = 1'b0;
  endtask
  task automatic stop_c;
    #TQ;
    sda_oe_o = 1'b1;
    #TQ;
    scl_o = 1'b1;
    #TQ;
    sda_oe_o = 1'b0;
    #(4 * TQ);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start_c();
    byte_io({4'hE, 3'h0, 1'b0}, 1'b1, q, k0);
    byte_io(ix, 1'b1, q, k1);
    byte_io(d, 1'b1, q, k2);
    stop_c();
    ok = !(k0 | k1 | k2);
  endtask
  // both bytes of a pair in one access
  task automatic rd(input logic [7:0] ix, output logic [15:0] v);
    logic [7:0] q;
    logic k;
    start_c();
    byte_io({4'hE, 3'h0, 1'b0}, 1'b1, q, k);
    byte_io(ix, 1'b1, q, k);
    start_c();
    byte_io({4'hE, 3'h0, 1'b1}, 1'b1, q, k);
    byte_io(8'hFF, 1'b0, v[7:0], k);
    byte_io(8'hFF, 1'b1, v[15:8], k);
    stop_c();
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
`include "gauge_map.vh"
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] cur = 16'h0000;
  logic [15:0] vol = 16'h0000;
  logic cdone = 1'b0;
  logic vdone = 1'b0;
  logic seen_abort = 1'b0;
  logic seen_start = 1'b0;
  logic first_volt = 1'b0;
  logic [2:0] asel = 3'h0;
  logic ok;
  logic [15:0] v, e;
  logic [7:0] rnd [16];
  int error_cnt = 0;
  int n_tests = 0;
  wire scl, h_oe, sda_oe, alm_oe, cvolt, cstart, cabort, psave;
  wire [15:0] charge;
  // pull-ups on both open-drain lines
  wire sda = (h_oe || sda_oe) ? 1'b0 : 1'b1;
  wire alarm_pin = alm_oe ? 1'b0 : 1'b1;
  logic [23:0] dflt [6] = '{24'h001100, 24'h0A0000, 24'h0C0000, 24'h0D0000,
    24'h100000, {8'h17, `PART_ID, 8'h00}};
  i2c_host u_host (.scl_o(scl), .sda_oe_o(h_oe), .sda_i(sda));
  gauge_regs u_dut (.MCLK_I(mclk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
    .SDA_OE_O(sda_oe), .ALARM_PIN_I(alarm_pin), .ALARM_PIN_O(), .ALARM_PIN_OE_O(alm_oe),
    .ADDR_SEL_I(asel), .CURRENT_I(cur), .VOLTAGE_I(vol), .CUR_DONE_I(cdone),
    .VOLT_DONE_I(vdone), .CONV_VOLT_O(cvolt), .CONV_START_O(cstart), .CONV_ABORT_O(cabort),
    .POWER_SAVE_O(psave), .CHARGE_O(charge));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // start and abort are one-cycle pulses inside a bus write, so latch them
  always @(negedge mclk) begin
    if (cabort) seen_abort <= 1'b1;
    if (cstart && !seen_start) begin
      seen_start <= 1'b1;
      first_volt <= cvolt;
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    u_host.wr(ix, d, ok);
    check("write acks", ok, 1);
    repeat (3) @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] ix, output logic [15:0] r);
    u_host.rd(ix, r);
  endtask
  task automatic pulse(input logic is_cur);
    @(negedge mclk);
    cdone = is_cur;
    vdone = !is_cur;
    @(negedge mclk);
    cdone = 1'b0;
    vdone = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #900000;
    error_cnt++;
    final_report();
  end
  initial begin
    void'($urandom(70));
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (5) @(negedge mclk);
    for (int i = 0; i < 6; i++) begin
      rd(dflt[i][23:16], v);
      check("reset value", v, dflt[i][15:0]);
    end
    $display("test defaults done");
    for (int i = 0; i < 16; i++) begin
      rnd[i] = 8'($urandom);
      wr(8'h20 + 8'(i), rnd[i]);
    end
    for (int i = 0; i < 16; i += 2) begin
      rd(8'h20 + 8'(i), v);
      check("scratch", v, {rnd[i+1], rnd[i]});
    end
    asel = 3'h5;
    repeat (3) @(negedge mclk);
    u_host.wr(8'h20, 8'h00, ok);
    check("wrong address nack", ok, 0);
    asel = 3'h0;
    repeat (3) @(negedge mclk);
    rd(8'h20, v);
    check("scratch kept", v, {rnd[1], rnd[0]});
    wr(8'h18, 8'hA5);
    rd(8'h17, v);
    check("id read only", v, {`PART_ID, 8'h00});
    e = 16'($urandom);
    wr(8'h0F, e[7:0]);
    rd(8'h0F, v);
    check("threshold", v[7:0], e[7:0]);
    wr(8'h00, 8'h04);
    check("power save", psave, 1);
    $display("test registers done");
    wr(8'h01, 8'h00);
    check("forced low", alm_oe, 1);
    rd(8'h01, v);
    check("pin readback", v[0], 0);
    wr(8'h01, 8'h01);
    check("released", alm_oe, 0);
    wr(8'h0C, 8'h00);
    wr(8'h0D, 8'h01);
    pulse(1);
    check("disabled alarm", alm_oe, 0);
    wr(8'h00, 8'h08);
    pulse(1);
    check("charge alarm pin", alm_oe, 1);
    rd(8'h01, v);
    check("charge flag", v[7:0] & 8'hF3, 8'h20);
    wr(8'h0D, 8'h80);
    pulse(1);
    check("latched low", alm_oe, 1);
    wr(8'h01, 8'h01);
    check("cleared", alm_oe, 0);
    wr(8'h0D, 8'h01);
    pulse(1);
    check("rearmed", alm_oe, 1);
    wr(8'h01, 8'h01);
    pulse(1);
    check("no retrigger", alm_oe, 0);
    wr(8'h0E, 8'h80);
    vol = {1'b0, 15'($urandom)};
    pulse(0);
    check("voltage alarm", alm_oe, 1);
    rd(8'h01, v);
    check("voltage flag", v[7:0] & 8'hF3, 8'h40);
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h00);
    $display("test alarm done");
    wr(8'h01, 8'h03);
    wr(8'h0A, e[7:0]);
    wr(8'h0B, e[15:8]);
    wr(8'h00, 8'h10);
    for (int i = 0; i < 8000 && !seen_start; i++) @(negedge mclk);
    check("first conversion", {seen_start, first_volt}, 2'b11);
    cur = 16'h1000;
    pulse(1);
    check("charge out", charge, e + 16'h0001);
    rd(8'h02, v);
    check("charge read", v, e + 16'h0001);
    wr(8'h0F, 8'h10);
    cur = 16'hFFFF;
    pulse(1);
    repeat (4) pulse(0);
    rd(8'h10, v);
    check("relax count", v[7:0], 8'h02);
    repeat (600) pulse(0);
    rd(8'h10, v);
    check("relax saturates", v[7:0], `RELAX_MAX);
    rd(8'h08, v);
    check("voltage read", v, vol);
    cur = 16'h0001;
    pulse(1);
    pulse(0);
    rd(8'h10, v);
    check("relax cleared", v[7:0], 8'h00);
    check("no early abort", seen_abort, 0);
    wr(8'h00, 8'h00);
    check("abort", seen_abort, 1);
    wr(8'h01, 8'h10);
    rd(8'h00, v);
    check("soft reset ctrl", v, 16'h1100);
    rd(8'h0A, v);
    check("soft reset base", v, 16'h0000);
    $display("test run done");
    final_report();
  end
endmodule
